// ==== design/eba_host.sv ====
// Processor-side sequencer: takes a byte job from software and plays the
// I/O writes to the EEPROM controller in the required order and timing.
// Assumes a plain software port with read data one cycle after the strobe.
`timescale 1ns/1ps
module eba_host (
   // Clock, reset, enable
   input  wire logic       sys_clk,
   input  wire logic       rst,
   input  wire logic       ce,
   // Software port
   input  wire logic [2:0] sw_addr,
   input  wire logic [7:0] sw_wdata,
   input  wire logic       sw_we,
   input  wire logic       sw_re,
   output logic      [7:0] sw_rdata_q,
   // Supply monitor level, high while the supply is too low
   input  wire logic       brownout_detector,
   // Device link
   eba_if.cpu              bus
);
   typedef enum logic [5:0] {
      H_IDLE = 6'b000001,
      H_RD   = 6'b000010,
      H_RW   = 6'b000100,
      H_RC   = 6'b001000,
      H_WR   = 6'b010000,
      H_GAP  = 6'b100000
   } eba_hst_t;

   eba_hst_t   st_q, st_d;
   logic [1:0] op_q, op_d;
   logic [8:0] a_q, a_d;
   logic [7:0] d_q, d_d;
   logic [2:0] step_q, step_d;
   logic       gie_q, gie_d;
   logic       done_q, done_d;
   logic       fetch_q, fetch_d;
   logic       pass_q, pass_d;
   logic       hold_q, hold_d;
   logic [5:0] io_addr_q, io_addr_d;
   logic [7:0] io_wdata_q, io_wdata_d;
   logic       io_we_q, io_we_d;
   logic       io_re_q, io_re_d;
   logic [7:0] sw_rdata_d;
   logic [14:0] item;

   // One I/O write of a job: {last, offset, data}
   function automatic logic [14:0] seq_item(input logic [1:0] op, input logic pass,
                                            input logic [2:0] step, input logic [8:0] a,
                                            input logic [7:0] d, input logic ie);
      logic [1:0] m;
      logic [7:0] c;
      logic [7:0] r;
      m = (op == eba_pkg::PM_WRITE && !pass) ? eba_pkg::PM_ERASE : op; // RQ11
      // Every control write restates the ready enable, so carry it along
      r = 8'(ie) << eba_pkg::CB_RIE; // RQ20
      c = (8'(m) << eba_pkg::CB_PM) | r;
      if (op == eba_pkg::OP_READ) begin
         case (step)
            3'h0:    seq_item = {1'b0, eba_pkg::IO_AHI, 7'h00, a[8]};
            3'h1:    seq_item = {1'b0, eba_pkg::IO_ALO, a[7:0]};
            default: seq_item = {1'b1, eba_pkg::IO_CTRL, (8'h01 << eba_pkg::CB_RE) | r};
         endcase
      end else begin
         case (step)
            3'h0:    seq_item = {1'b0, eba_pkg::IO_CTRL, c};
            3'h1:    seq_item = {1'b0, eba_pkg::IO_AHI, 7'h00, a[8]};
            3'h2:    seq_item = {1'b0, eba_pkg::IO_ALO, a[7:0]};
            3'h3:    seq_item = {1'b0, eba_pkg::IO_DATA, d};
            3'h4:    seq_item = {1'b0, eba_pkg::IO_CTRL, c | (8'h01 << eba_pkg::CB_MPE)};
            default: seq_item = {1'b1, eba_pkg::IO_CTRL, c | (8'h01 << eba_pkg::CB_PE)};
         endcase
      end
   endfunction

   // Software registers and job sequencer
   always_comb begin
      st_d = st_q;
      op_d = op_q;
      a_d = a_q;
      d_d = d_q;
      step_d = step_q;
      gie_d = gie_q;
      done_d = done_q;
      fetch_d = fetch_q;
      pass_d = pass_q;
      hold_d = brownout_detector; // RQ16
      io_addr_d = io_addr_q;
      io_wdata_d = io_wdata_q;
      io_we_d = 1'b0;
      io_re_d = 1'b0;
      sw_rdata_d = 8'h00;
      item = seq_item(op_q, pass_q, step_q, a_q, d_q, gie_q);

      // Job setup only while idle so a running job sees stable values
      if (sw_we) begin
         case (sw_addr)
            eba_pkg::SW_CMD: begin
               if (st_q == H_IDLE) begin
                  op_d = sw_wdata[1:0];
                  st_d = H_RD;
                  step_d = 3'h0;
                  fetch_d = 1'b0;
                  pass_d = 1'b0;
                  done_d = 1'b0;
               end
            end
            eba_pkg::SW_ALO:  if (st_q == H_IDLE) a_d[7:0] = sw_wdata;
            eba_pkg::SW_AHI:  if (st_q == H_IDLE) a_d[8] = sw_wdata[0];
            eba_pkg::SW_DATA: if (st_q == H_IDLE) d_d = sw_wdata;
            eba_pkg::SW_CFG:  gie_d = sw_wdata[0];
            default: ;
         endcase
      end
      if (sw_re) begin
         case (sw_addr)
            eba_pkg::SW_ALO:  sw_rdata_d = a_q[7:0];
            eba_pkg::SW_AHI:  sw_rdata_d = {7'h00, a_q[8]};
            eba_pkg::SW_DATA: sw_rdata_d = d_q;
            eba_pkg::SW_STAT: sw_rdata_d = {5'h00, bus.irq, done_q, st_q != H_IDLE};
            eba_pkg::SW_CFG:  sw_rdata_d = {7'h00, gie_q};
            default:          sw_rdata_d = 8'h00;
         endcase
      end

      case (st_q)
         H_IDLE: ;
         H_RD: begin
            io_re_d = 1'b1;
            io_addr_d = fetch_q ? eba_pkg::IO_DATA : eba_pkg::IO_CTRL;
            st_d = H_RW;
         end
         H_RW: st_d = H_RC;
         H_RC: begin
            if (fetch_q) begin
               d_d = bus.io_rdata;
               done_d = 1'b1;
               st_d = H_IDLE;
            end else if (bus.io_rdata[eba_pkg::CB_PE]) begin
               st_d = H_RD; // RQ14
            end else begin
               step_d = 3'h0;
               st_d = H_WR;
            end
         end
         H_WR: begin
            io_we_d = 1'b1; // RQ15
            io_addr_d = item[13:8];
            io_wdata_d = item[7:0];
            st_d = H_GAP;
         end
         H_GAP: begin
            // Halt is only visible the cycle after the strobe, hence the we check
            if (!io_we_q && !bus.halt) begin
               if (!item[14]) begin
                  step_d = step_q + 3'h1; // RQ5
                  st_d = H_WR;
               end else if (op_q == eba_pkg::OP_READ) begin
                  fetch_d = 1'b1;
                  st_d = H_RD;
               end else if (op_q == eba_pkg::PM_WRITE && !pass_q) begin
                  pass_d = 1'b1; // RQ11
                  st_d = H_RD;
               end else begin
                  done_d = 1'b1;
                  st_d = H_IDLE;
               end
            end
         end
         default: st_d = H_IDLE;
      endcase
   end

   // State registers
   always_ff @(posedge sys_clk) begin
      if (ce) begin
         if (rst) begin
            st_q <= H_IDLE;
            op_q <= 2'h0;
            a_q <= 9'h000;
            d_q <= 8'h00;
            step_q <= 3'h0;
            gie_q <= 1'b0;
            done_q <= 1'b0;
            fetch_q <= 1'b0;
            pass_q <= 1'b0;
            hold_q <= 1'b0;
            io_addr_q <= 6'h00;
            io_wdata_q <= 8'h00;
            io_we_q <= 1'b0;
            io_re_q <= 1'b0;
            sw_rdata_q <= 8'h00;
         end else begin
            st_q <= st_d;
            op_q <= op_d;
            a_q <= a_d;
            d_q <= d_d;
            step_q <= step_d;
            gie_q <= gie_d;
            done_q <= done_d;
            fetch_q <= fetch_d;
            pass_q <= pass_d;
            hold_q <= hold_d;
            io_addr_q <= io_addr_d;
            io_wdata_q <= io_wdata_d;
            io_we_q <= io_we_d;
            io_re_q <= io_re_d;
            sw_rdata_q <= sw_rdata_d;
         end
      end
   end

   // Link outputs, all registered
   assign bus.io_addr  = io_addr_q;
   assign bus.io_wdata = io_wdata_q;
   assign bus.io_we    = io_we_q;
   assign bus.io_re    = io_re_q;
   assign bus.gie      = gie_q;
   assign bus.hold_rst = hold_q;
endmodule

// ==== design/eba_pkg.sv ====
// Shared constants and types for the byte EEPROM controller and its CPU-side sequencer.
// Assumes both ends run on one 25 MHz sys_clk with a synchronous active-high reset.
package eba_pkg;
   // Clock period and programming times
   localparam int unsigned CLK_NS      = 40;
   localparam int unsigned T_ATOMIC_NS = 3_400_000;
   localparam int unsigned T_SPLIT_NS  = 1_800_000;
   localparam int unsigned ATOMIC_CYC  = T_ATOMIC_NS / CLK_NS;
   localparam int unsigned SPLIT_CYC   = T_SPLIT_NS / CLK_NS;

   // Storage geometry, largest variant; smaller parts ignore high address bits
   localparam int unsigned EE_BYTES = 512;
   localparam int unsigned EE_AW    = 9;

   // Device offsets in the processor I/O space
   localparam logic [5:0] IO_AHI  = 6'h1f;
   localparam logic [5:0] IO_ALO  = 6'h1e;
   localparam logic [5:0] IO_DATA = 6'h1d;
   localparam logic [5:0] IO_CTRL = 6'h1c;

   // Control register bit positions
   localparam int unsigned CB_RE  = 0;
   localparam int unsigned CB_PE  = 1;
   localparam int unsigned CB_MPE = 2;
   localparam int unsigned CB_RIE = 3;
   localparam int unsigned CB_PM  = 4;

   // Cycle counts for the enable window and processor stalls
   localparam logic [2:0] MPE_WIN = 3'h4;
   localparam logic [2:0] RD_HALT = 3'h4;
   localparam logic [2:0] PG_HALT = 3'h2;

   // Reset and erased values
   localparam logic [7:0] DATA_RST = 8'h00;
   localparam logic [7:0] ERASED   = 8'hff;

   // Program mode codes
   typedef enum logic [1:0] {
      PM_ATOMIC = 2'h0,
      PM_ERASE  = 2'h1,
      PM_WRITE  = 2'h2,
      PM_RSVD   = 2'h3
   } eba_mode_t;
   localparam eba_mode_t MODE_RST = PM_ATOMIC;

   // Sequencer register offsets and the read opcode
   localparam logic [2:0] SW_CMD  = 3'h0;
   localparam logic [2:0] SW_ALO  = 3'h1;
   localparam logic [2:0] SW_AHI  = 3'h2;
   localparam logic [2:0] SW_DATA = 3'h3;
   localparam logic [2:0] SW_STAT = 3'h4;
   localparam logic [2:0] SW_CFG  = 3'h5;
   localparam logic [1:0] OP_READ = 2'h3;

   // Saturating decrement shared by the small down-counters
   function automatic logic [2:0] dec3(input logic [2:0] v);
      dec3 = (v == 3'h0) ? 3'h0 : v - 3'h1;
   endfunction
endpackage

// ==== design/eba_if.sv ====
// I/O-space link between the processor-side sequencer and the EEPROM controller.
// Assumes both ends share sys_clk; every signal is driven from a flip-flop.
`timescale 1ns/1ps
interface eba_if;
   logic [5:0] io_addr;
   logic [7:0] io_wdata;
   logic       io_we;
   logic       io_re;
   logic [7:0] io_rdata;
   logic       halt;
   logic       irq;
   logic       gie;
   logic       hold_rst;

   modport dev (
      input  io_addr, io_wdata, io_we, io_re, gie, hold_rst,
      output io_rdata, halt, irq
   );
   modport cpu (
      output io_addr, io_wdata, io_we, io_re, gie, hold_rst,
      input  io_rdata, halt, irq
   );
endinterface

// ==== design/eba_prog_timer.sv ====
// Programming duration timer paced by the calibrated oscillator tick.
// Assumes osc_tick is a one-cycle enable synchronous to sys_clk.
`timescale 1ns/1ps
module eba_prog_timer #(
   parameter int unsigned ATOMIC_CYC = eba_pkg::ATOMIC_CYC,
   parameter int unsigned SPLIT_CYC  = eba_pkg::SPLIT_CYC
) (
   // Clock, reset, enable
   input  wire logic sys_clk,
   input  wire logic rst,
   input  wire logic ce,
   // Oscillator pacing
   input  wire logic osc_tick,
   // Operation control and state
   input  wire logic start,
   input  wire logic long_op,
   output logic      busy_q,
   output logic      done_q
);
   localparam int unsigned CW = $clog2(ATOMIC_CYC + 1);

   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;
   logic          busy_d;
   logic          done_d;

   // Count oscillator ticks, not processor clocks
   always_comb begin
      cnt_d  = cnt_q;
      done_d = 1'b0;
      if (busy_q) begin
         if (osc_tick) begin
            cnt_d  = cnt_q - 1'b1; // RQ12
            done_d = (cnt_q == CW'(1));
         end
      end else if (start) begin
         cnt_d = long_op ? CW'(ATOMIC_CYC) : CW'(SPLIT_CYC); // RQ17
      end
      busy_d = (cnt_d != '0);
   end

   // Reset only lands when idle, so a running program finishes; the test is
   // written so that an unknown busy at power-up falls into the reset branch
   always_ff @(posedge sys_clk) begin
      if (ce) begin
         if (!rst || busy_q) begin // RQ13
            cnt_q  <= cnt_d;
            busy_q <= busy_d;
            done_q <= done_d;
         end else begin
            cnt_q  <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
         end
      end
   end
endmodule

// ==== design/eba_dev.sv ====
// Byte EEPROM controller: I/O-mapped address, data and control registers,
// read, atomic, erase-only and write-only operations, stalls and ready interrupt.
// Assumes the processor honours halt and issues at most one I/O strobe per cycle.
`timescale 1ns/1ps

// Contract
// RQ1: 512-byte storage, single bytes read and written
// RQ2: Registers sit in processor I/O space
// RQ3: Read stalls processor four cycles
// RQ4: Program start stalls processor two cycles
// RQ5: Program strobe only within enable window
// RQ6: Mode zero erases then writes byte
// RQ7: Mode one erases byte only
// RQ8: Mode two writes byte without erase
// RQ9: Program strobe reads busy until done
// RQ10: No new operation while programming
// RQ11: Software erases before write-only
// RQ12: Programming timed from calibrated oscillator
// RQ13: Reset lets running program complete
// RQ14: Software polls busy before next access
// RQ15: Software loads address, data before trigger
// RQ16: Hold reset while supply too low
// RQ17: Times 3.4 ms combined, 1.8 ms split
// RQ18: Enable clears after four; mode locked busy
// RQ19: Read fetches byte; address locked busy
// RQ20: Ready interrupt level when enabled, idle
// RQ21: Reserved mode strobe starts nothing
module eba_dev #(
   parameter int unsigned ATOMIC_CYC = eba_pkg::ATOMIC_CYC,
   parameter int unsigned SPLIT_CYC  = eba_pkg::SPLIT_CYC
) (
   // Clock, reset, enable
   input  wire logic sys_clk,
   input  wire logic rst,
   input  wire logic ce,
   // Calibrated oscillator tick
   input  wire logic osc_tick,
   // Programming state for the user side
   output logic      prog_busy,
   // Processor I/O link
   eba_if.dev        bus
);
   // Nonvolatile array; no reset, contents survive
   logic [7:0] mem [eba_pkg::EE_BYTES]; // RQ1

   // Register state
   logic [8:0]         addr_q;
   logic [8:0]         addr_d;
   logic [7:0]         data_q;
   logic [7:0]         data_d;
   eba_pkg::eba_mode_t mode_q;
   eba_pkg::eba_mode_t mode_d;
   logic               rie_q;
   logic               rie_d;
   logic [2:0]         mpe_q;
   logic [2:0]         mpe_d;
   logic [2:0]         hcnt_q;
   logic [2:0]         hcnt_d;
   logic               halt_q;
   logic               halt_d;
   logic [7:0]         rdata_q;
   logic [7:0]         rdata_d;
   logic               irq_q;
   logic               irq_d;

   // Latched operation, stable for the whole programming time
   eba_pkg::eba_mode_t op_mode_q;
   eba_pkg::eba_mode_t op_mode_d;
   logic [8:0]         op_addr_q;
   logic [8:0]         op_addr_d;
   logic [7:0]         op_data_q;
   logic [7:0]         op_data_d;

   // Strobe decode and array write port
   logic       hard_rst;
   logic       busy;
   logic       tmr_done;
   logic       wr_ctl;
   logic       start;
   logic       rd_go;
   logic       mem_we;
   logic [7:0] mem_wd;

   // Brownout hold acts as an extra system reset
   assign hard_rst = rst | bus.hold_rst;
   assign busy     = prog_busy;

   // Control write decode
   assign wr_ctl = bus.io_we && (bus.io_addr == eba_pkg::IO_CTRL); // RQ2

   // Program strobe counts only inside the enable window, idle, valid mode
   assign start = wr_ctl && bus.io_wdata[eba_pkg::CB_PE] // RQ5
                  && (mpe_q != 3'h0)
                  && !busy // RQ10
                  && (mode_q != eba_pkg::PM_RSVD); // RQ21

   // Read strobe is dropped while programming
   assign rd_go = wr_ctl && bus.io_wdata[eba_pkg::CB_RE] && !busy && !start; // RQ10

   // Programming duration; atomic takes the long time
   eba_prog_timer #(
      .ATOMIC_CYC (ATOMIC_CYC),
      .SPLIT_CYC  (SPLIT_CYC)
   ) u_timer (
      .sys_clk  (sys_clk),
      .rst      (hard_rst),
      .ce       (ce),
      .osc_tick (osc_tick),
      .start    (start),
      .long_op  (mode_q == eba_pkg::PM_ATOMIC),
      .busy_q   (prog_busy),
      .done_q   (tmr_done)
   );

   // Register next values
   always_comb begin
      addr_d    = addr_q;
      data_d    = data_q;
      mode_d    = mode_q;
      rie_d     = rie_q;
      mpe_d     = eba_pkg::dec3(mpe_q); // RQ18
      hcnt_d    = eba_pkg::dec3(hcnt_q);
      op_mode_d = op_mode_q;
      op_addr_d = op_addr_q;
      op_data_d = op_data_q;
      rdata_d   = 8'h00;

      // Register writes from the processor
      if (bus.io_we) begin
         case (bus.io_addr)
            eba_pkg::IO_AHI: begin
               if (!busy) begin
                  addr_d[8] = bus.io_wdata[0]; // RQ19
               end
            end
            eba_pkg::IO_ALO: begin
               if (!busy) begin
                  addr_d[7:0] = bus.io_wdata; // RQ19
               end
            end
            eba_pkg::IO_DATA: begin
               data_d = bus.io_wdata;
            end
            eba_pkg::IO_CTRL: begin
               if (!busy) begin
                  mode_d = eba_pkg::eba_mode_t'(bus.io_wdata[eba_pkg::CB_PM +: 2]); // RQ18
               end
               rie_d = bus.io_wdata[eba_pkg::CB_RIE];
               if (bus.io_wdata[eba_pkg::CB_MPE]) begin
                  mpe_d = eba_pkg::MPE_WIN; // RQ18
               end
            end
            default: ;
         endcase
      end

      // A read fetches the addressed byte at once, then stalls the core
      if (rd_go) begin
         data_d = mem[addr_q]; // RQ19
         hcnt_d = eba_pkg::RD_HALT; // RQ3
      end

      // Program start latches the job so later data writes cannot disturb it
      if (start) begin
         op_mode_d = mode_q;
         op_addr_d = addr_q;
         op_data_d = data_q;
         hcnt_d    = eba_pkg::PG_HALT; // RQ4
      end

      // Register reads; answer stands one cycle only
      if (bus.io_re) begin
         case (bus.io_addr)
            eba_pkg::IO_AHI:  rdata_d = {7'h00, addr_q[8]};
            eba_pkg::IO_ALO:  rdata_d = addr_q[7:0];
            eba_pkg::IO_DATA: rdata_d = data_q;
            eba_pkg::IO_CTRL: rdata_d = {2'h0, mode_q, rie_q, mpe_q != 3'h0, busy, 1'b0}; // RQ9
            default:          rdata_d = 8'h00;
         endcase
      end

      halt_d = (hcnt_d != 3'h0);
      irq_d  = rie_q && bus.gie && !busy; // RQ20
   end

   // Array update at the end of the programming time
   always_comb begin
      mem_we = tmr_done;
      case (op_mode_q)
         eba_pkg::PM_ATOMIC: mem_wd = op_data_q; // RQ6
         eba_pkg::PM_ERASE:  mem_wd = eba_pkg::ERASED; // RQ7
         eba_pkg::PM_WRITE:  mem_wd = mem[op_addr_q] & op_data_q; // RQ8
         default:            mem_wd = mem[op_addr_q];
      endcase
   end

   // Register update; a reset during programming keeps the job and its mode
   always_ff @(posedge sys_clk) begin
      if (ce) begin
         if (hard_rst) begin
            data_q  <= eba_pkg::DATA_RST;
            rie_q   <= 1'b0;
            mpe_q   <= 3'h0;
            hcnt_q  <= 3'h0;
            halt_q  <= 1'b0;
            rdata_q <= 8'h00;
            irq_q   <= 1'b0;
            if (!busy) begin // RQ13
               mode_q    <= eba_pkg::MODE_RST;
               addr_q    <= 9'h000;
               op_mode_q <= eba_pkg::MODE_RST;
               op_addr_q <= 9'h000;
               op_data_q <= eba_pkg::DATA_RST;
            end
         end else begin
            addr_q    <= addr_d;
            data_q    <= data_d;
            mode_q    <= mode_d;
            rie_q     <= rie_d;
            mpe_q     <= mpe_d;
            hcnt_q    <= hcnt_d;
            halt_q    <= halt_d;
            rdata_q   <= rdata_d;
            irq_q     <= irq_d;
            op_mode_q <= op_mode_d;
            op_addr_q <= op_addr_d;
            op_data_q <= op_data_d;
         end
      end
   end

   // Array write; runs even under reset so a started program lands
   always_ff @(posedge sys_clk) begin
      if (ce && mem_we) begin
         mem[op_addr_q] <= mem_wd; // RQ13
      end
   end

   // Link outputs, all registered
   assign bus.io_rdata = rdata_q;
   assign bus.halt     = halt_q;
   assign bus.irq      = irq_q;
endmodule

// ==== testbench/eba_props.sv ====
// Checker for the I/O link between the host sequencer and the device.
// Assumes it sits beside the shared eba_if and also sees busy and the tick.
`timescale 1ns/1ps
module eba_props #(
   parameter int unsigned ATOMIC_CYC = 20,
   parameter int unsigned SPLIT_CYC  = 10
) (
   // Clock and resets
   input wire logic       sys_clk,
   input wire logic       rst,
   input wire logic       hold_rst,
   // Link signals
   input wire logic [5:0] io_addr,
   input wire logic [7:0] io_wdata,
   input wire logic       io_we,
   input wire logic       io_re,
   input wire logic [7:0] io_rdata,
   input wire logic       halt,
   input wire logic       irq,
   input wire logic       gie,
   // Device state and pacing
   input wire logic       prog_busy,
   input wire logic       osc_tick
);
   logic        ctl_wr, pe_wr, rd_go, live_d;
   logic        live_q = 1'b0;
   logic [2:0]  age_q, age_d;
   logic [1:0]  mode_q, mode_d, run_q, run_d;
   logic [31:0] tick_q, tick_d, exp_n;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst || hold_rst);
   // Decoded control writes
   assign ctl_wr = io_we && (io_addr == eba_pkg::IO_CTRL);
   assign pe_wr  = ctl_wr && io_wdata[eba_pkg::CB_PE];
   assign rd_go  = ctl_wr && io_wdata[eba_pkg::CB_RE] && !pe_wr && !prog_busy;
   assign exp_n  = (run_q == 2'h0) ? ATOMIC_CYC : SPLIT_CYC;
   // Enable age saturates so a stale window never wraps back open
   always_comb begin
      age_d = (age_q == 3'h7) ? age_q : age_q + 3'h1;
      if (ctl_wr && io_wdata[eba_pkg::CB_MPE])
         age_d = 3'h0;
      if (rst)
         age_d = 3'h7;
      mode_d = (ctl_wr && !prog_busy) ? io_wdata[5:4] : mode_q;
      run_d  = (pe_wr && !prog_busy) ? mode_q : run_q;
      tick_d = prog_busy ? tick_q + {31'h0, osc_tick} : 32'h0;
      live_d = live_q | (rst & !prog_busy);
   end
   // Tick count keeps going through reset, as the job itself must
   always_ff @(posedge sys_clk) begin
      age_q  <= age_d;
      mode_q <= mode_d;
      run_q  <= run_d;
      tick_q <= tick_d;
      live_q <= live_d;
   end
   a_read_halt_four: assert property (rd_go |=> halt [*4] ##1 !halt)
      else $error("read stall length wrong");
   a_prog_halt_two: assert property ($rose(prog_busy) |-> halt ##1 halt ##1 !halt)
      else $error("program stall length wrong");
   a_start_window: assert property ($rose(prog_busy) |-> $past(pe_wr) && $past(age_q) < 3'h4)
      else $error("program started outside enable window");
   a_busy_ticks: assert property (disable iff (rst || !live_q) $fell(prog_busy) |-> tick_q == exp_n)
      else $error("busy length in ticks wrong");
   a_no_restart: assert property ($rose(halt) |-> !$past(prog_busy))
      else $error("access accepted while busy");
   a_halt_cause: assert property ($rose(halt) |-> $past(ctl_wr))
      else $error("stall without control write");
   a_rdata_slot: assert property (io_rdata != 8'h00 |-> $past(io_re))
      else $error("read data outside its slot");
   a_irq_ready: assert property (irq |-> $past(gie) && !$past(prog_busy))
      else $error("ready interrupt while not ready");
   c_atomic: cover property ($fell(prog_busy) && run_q == 2'h0);
   c_erase: cover property ($fell(prog_busy) && run_q == 2'h1);
   c_write: cover property ($fell(prog_busy) && run_q == 2'h2);
   c_read: cover property (rd_go);
endmodule

// ==== testbench/test_eeprom_byte_access_controller.sv ====
// Self-checking bench: host sequencer and device joined by eba_if.
// Assumes short programming counts and an oscillator tick every other cycle.
`timescale 1ns/1ps
module test_eeprom_byte_access_controller;
   logic       sys_clk = 1'b0;
   logic       rst = 1'b1;
   logic       ce = 1'b1;
   logic       osc_tick = 1'b0;
   logic       brownout_detector = 1'b0;
   logic [2:0] sw_addr = 3'h0;
   logic [7:0] sw_wdata = 8'h00;
   logic       sw_we = 1'b0;
   logic       sw_re = 1'b0;
   logic [7:0] sw_rdata_q, v;
   logic       prog_busy;
   int         n_fail = 0;
   int         checked = 0;
   int         cyc = 0;
   eba_if bus ();
   eba_dev #(.ATOMIC_CYC(20), .SPLIT_CYC(10)) u_eba_dev (.sys_clk(sys_clk), .rst(rst),
      .ce(ce), .osc_tick(osc_tick), .prog_busy(prog_busy), .bus(bus));
   eba_host u_eba_host (.sys_clk(sys_clk), .rst(rst), .ce(ce), .sw_addr(sw_addr),
      .sw_wdata(sw_wdata), .sw_we(sw_we), .sw_re(sw_re), .sw_rdata_q(sw_rdata_q),
      .brownout_detector(brownout_detector), .bus(bus));
   eba_props #(.ATOMIC_CYC(20), .SPLIT_CYC(10)) u_eba_props (.sys_clk(sys_clk), .rst(rst),
      .hold_rst(bus.hold_rst), .io_addr(bus.io_addr), .io_wdata(bus.io_wdata),
      .io_we(bus.io_we), .io_re(bus.io_re), .io_rdata(bus.io_rdata), .halt(bus.halt),
      .irq(bus.irq), .gie(bus.gie), .prog_busy(prog_busy), .osc_tick(osc_tick));
   always #20 sys_clk = ~sys_clk;
   // Tick at half rate so timer pacing differs from the bus clock
   always @(posedge sys_clk) osc_tick <= ~osc_tick;
   // Hang guard, far above the several hundred cycles the tests need
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail = n_fail + 1;
         test_done();
      end
   end
   task automatic test_done();
      $display("checks %0d fails %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Software port cycles
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      sw_addr <= a;
      sw_wdata <= d;
      sw_we <= 1'b1;
      @(posedge sys_clk);
      sw_we <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a);
      @(posedge sys_clk);
      sw_addr <= a;
      sw_re <= 1'b1;
      @(posedge sys_clk);
      sw_re <= 1'b0;
      #1 v = sw_rdata_q;
   endtask
   // Poll status until idle and done; give up after 400 reads and fail the check
   task automatic wait_done();
      v = 8'h01;
      for (int i = 0; i < 400 && v[1:0] !== 2'h2; i++) rd(eba_pkg::SW_STAT);
      chk(v & 8'h03, 8'h02);
   endtask
   task automatic put(input logic [8:0] a, input logic [7:0] d, input logic [1:0] op);
      wr(eba_pkg::SW_ALO, a[7:0]);
      wr(eba_pkg::SW_AHI, {7'h00, a[8]});
      wr(eba_pkg::SW_DATA, d);
      wr(eba_pkg::SW_CMD, {6'h00, op});
      wait_done();
   endtask
   task automatic get(input logic [8:0] a, input logic [7:0] exp);
      put(a, 8'h00, eba_pkg::OP_READ);
      rd(eba_pkg::SW_DATA);
      chk(v, exp);
   endtask
   // Atomic store, then a data write while busy must not leak in
   task automatic t_atomic();
      put(9'h1a5, 8'h3c, 2'h0);
      get(9'h1a5, 8'h3c);
      // Idle after a read with interrupts on: ready, done, not busy
      rd(eba_pkg::SW_STAT);
      chk(v, 8'h06);
      wr(eba_pkg::SW_DATA, 8'h55);
      wr(eba_pkg::SW_CMD, 8'h00);
      wr(eba_pkg::SW_DATA, 8'haa);
      wait_done();
      get(9'h1a5, 8'h55);
      $display("test atomic done");
   endtask
   // Erase only, then write only on a neighbour differing in the top bit
   task automatic t_modes();
      put(9'h1a5, 8'h00, 2'h1);
      get(9'h1a5, eba_pkg::ERASED);
      put(9'h0a5, 8'h96, 2'h2);
      get(9'h0a5, 8'h96);
      get(9'h1a5, eba_pkg::ERASED);
      $display("test modes done");
   endtask
   // Reset with low supply in mid-programming must not abort the job
   task automatic t_reset();
      wr(eba_pkg::SW_DATA, 8'h4b);
      wr(eba_pkg::SW_CMD, 8'h00);
      repeat (30) @(posedge sys_clk);
      rst <= 1'b1;
      brownout_detector <= 1'b1;
      repeat (4) @(posedge sys_clk);
      rst <= 1'b0;
      // Low supply outlasts rst by one edge so the held reset reaches the device
      @(posedge sys_clk);
      brownout_detector <= 1'b0;
      @(posedge sys_clk);
      #1 chk({7'h00, prog_busy}, 8'h01);
      for (int i = 0; i < 200 && prog_busy !== 1'b0; i++) @(posedge sys_clk);
      get(9'h1a5, 8'h4b);
      $display("test reset done");
   endtask
   initial begin
      repeat (12) @(posedge sys_clk);
      rst <= 1'b0;
      wr(eba_pkg::SW_CFG, 8'h01);
      rd(eba_pkg::SW_CFG);
      chk(v, 8'h01);
      t_atomic();
      t_modes();
      t_reset();
      test_done();
   end
endmodule
